// file: inc/hiwc_pkg.sv
/*
  package for the halt / idle / wake-up controller: mode encodings,
  settle counts and widths shared by the controller, its checker and the testbench.
  assumes a single 125 MHz clock domain and a synchronous active high reset.
*/
package hiwc_pkg;
  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int HIWC_PA_W = 8;
  localparam int HIWC_IRQ_W = 8;
  localparam int HIWC_CLK_MHZ = 125;
  localparam int HIWC_HOSC_SETTLE_CYC = 1024;
  localparam int HIWC_LOSC_SETTLE_CYC = 1024;
  localparam int HIWC_SETTLE_W = 11;
  localparam logic [HIWC_SETTLE_W-1:0] HIWC_SETTLE_RST = 11'h000;
  localparam logic HIWC_PDF_RST = 1'b0;
  localparam logic HIWC_TO_RST = 1'b0;

  // ****************************************************************
  // controller states, one-hot
  // ****************************************************************
  typedef enum logic [6:0] {
    HIWC_RUN = 7'h01,
    HIWC_IDLE_OFF = 7'h02,
    HIWC_IDLE_ON = 7'h04,
    HIWC_SLEEP_OFF = 7'h08,
    HIWC_SLEEP_WDT = 7'h10,
    HIWC_SETTLE_H = 7'h20,
    HIWC_SETTLE_L = 7'h40
  } hiwc_state_t;

  // resume kinds reported to the core
  typedef enum logic [1:0] {
    HIWC_RES_NONE = 2'h0,
    HIWC_RES_NEXT = 2'h1,
    HIWC_RES_IRQ = 2'h2,
    HIWC_RES_WDT = 2'h3
  } hiwc_resume_t;
endpackage

// file: hdl/hiwc_sync_fall.sv
/*
  two-flop synchroniser with a falling edge detector per bit.
  assumes the inputs are asynchronous pins; edge uses only the second and third flops.
*/
`timescale 1ns/10ps
module hiwc_sync_fall #(
  parameter int W = 8
) (
  clk,
  srst,
  pin_in,
  level_out,
  fall_out
);
  input wire logic clk;
  input wire logic srst;
  input wire logic [W-1:0] pin_in;
  output logic [W-1:0] level_out;
  output logic [W-1:0] fall_out;

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first flop feeds only the second; reset to high so no false fall
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign fall_out = prev_q & ~sync_q;
endmodule

// file: hdl/hiwc_ctrl.sv
/*
  halt / idle / wake-up controller: picks the power mode on a halt,
  gates the clocks, clears the watchdog, keeps the power-down and time-out
  flags, detects wake sources and tells the core how to resume.
  assumes the core pulses halt_exec and wdt_clr_exec for one clock, and that
  oscillator ready levels and port A pins are asynchronous.
*/
`timescale 1ns/10ps
module hiwc_ctrl
  import hiwc_pkg::*;
#(
  parameter int PA_W = HIWC_PA_W,
  parameter int IRQ_W = HIWC_IRQ_W
) (
  clk,
  srst,
  halt_exec,
  wdt_clr_exec,
  idle_select,
  sysclk_in_idle_on,
  wdt_enable,
  wdt_on_sub,
  low_voltage_detect,
  fast_wake_enable,
  hosc_is_sys,
  sys_on_slow,
  high_osc_stable,
  low_osc_stable,
  ext_reset_wake,
  wdt_overflow,
  porta_pins,
  porta_wake_enable,
  irq_req,
  irq_enable,
  stack_full,
  cpu_halted,
  sys_clk_en,
  tb_clk_en,
  sub_clk_en,
  wdt_clk_en,
  wdt_clear,
  periph_on_slow,
  high_osc_en,
  low_osc_en,
  high_osc_ready,
  power_down_flag,
  watchdog_timeout_flag,
  full_reset,
  pc_sp_reset,
  resume_pulse,
  resume_kind,
  irq_take,
  slow_switch_ok,
  mode_state
);
  input wire logic clk;
  input wire logic srst;
  input wire logic halt_exec;
  input wire logic wdt_clr_exec;
  input wire logic idle_select;
  input wire logic sysclk_in_idle_on;
  input wire logic wdt_enable;
  input wire logic wdt_on_sub;
  input wire logic low_voltage_detect;
  input wire logic fast_wake_enable;
  input wire logic hosc_is_sys;
  input wire logic sys_on_slow;
  input wire logic high_osc_stable;
  input wire logic low_osc_stable;
  input wire logic ext_reset_wake;
  input wire logic wdt_overflow;
  input wire logic [PA_W-1:0] porta_pins;
  input wire logic [PA_W-1:0] porta_wake_enable;
  input wire logic [IRQ_W-1:0] irq_req;
  input wire logic [IRQ_W-1:0] irq_enable;
  input wire logic stack_full;
  output logic cpu_halted;
  output logic sys_clk_en;
  output logic tb_clk_en;
  output logic sub_clk_en;
  output logic wdt_clk_en;
  output logic wdt_clear;
  output logic periph_on_slow;
  output logic high_osc_en;
  output logic low_osc_en;
  output logic high_osc_ready;
  output logic power_down_flag;
  output logic watchdog_timeout_flag;
  output logic full_reset;
  output logic pc_sp_reset;
  output logic resume_pulse;
  output hiwc_resume_t resume_kind;
  output logic [IRQ_W-1:0] irq_take;
  output logic slow_switch_ok;
  output hiwc_state_t mode_state;

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  logic [PA_W-1:0] pa_fall;
  logic [IRQ_W-1:0] irq_s;
  logic [1:0] osc_s;
  logic [1:0] rst_s;
  logic [IRQ_W+3:0] misc_meta_q;
  logic [IRQ_W+3:0] misc_sync_q;

  // port A pins: synchronise then falling edge
  hiwc_sync_fall #(.W(PA_W)) u_pa_sync (
    .clk(clk),
    .srst(srst),
    .pin_in(porta_pins),
    .level_out(),
    .fall_out(pa_fall)
  );

  // irq requests, oscillator ready and reset sources are asynchronous too
  always_ff @(posedge clk) begin
    if (srst) begin
      misc_meta_q <= '0;
      misc_sync_q <= '0;
    end else begin
      misc_meta_q <= {irq_req, high_osc_stable, low_osc_stable, ext_reset_wake, wdt_overflow};
      misc_sync_q <= misc_meta_q;
    end
  end
  assign irq_s = misc_sync_q[IRQ_W+3:4];
  assign osc_s = misc_sync_q[3:2];
  assign rst_s = misc_sync_q[1:0];

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  hiwc_state_t state_q;
  hiwc_state_t state_d;
  localparam int SETTLE_W_L = HIWC_SETTLE_W;
  logic [SETTLE_W_L-1:0] cnt_q;
  logic [IRQ_W-1:0] irq_armed_q;
  logic low_pending_q;
  logic asleep;
  logic sleep_kind;
  logic [IRQ_W-1:0] irq_wake;
  logic pa_wake;
  logic any_wake;
  logic fast_ok;
  logic cnt_done_h;
  logic cnt_done_l;

  assign asleep = (state_q == HIWC_IDLE_OFF) || (state_q == HIWC_IDLE_ON) ||
                  (state_q == HIWC_SLEEP_OFF) || (state_q == HIWC_SLEEP_WDT);
  assign sleep_kind = wdt_enable | low_voltage_detect;
  // only requests that rose after entry may wake
  assign irq_wake = irq_s & irq_armed_q;
  assign pa_wake = |(pa_fall & porta_wake_enable);
  assign any_wake = asleep & (rst_s[1] | rst_s[0] | pa_wake | (|irq_wake));
  assign fast_ok = (state_q == HIWC_SLEEP_WDT) & hosc_is_sys & fast_wake_enable;
  assign cnt_done_h = (cnt_q == SETTLE_W_L'(HIWC_HOSC_SETTLE_CYC - 1));
  assign cnt_done_l = (cnt_q == SETTLE_W_L'(HIWC_LOSC_SETTLE_CYC - 1));

  // next mode
  always_comb begin
    state_d = state_q;
    case (state_q)
      HIWC_RUN: begin
        if (halt_exec) begin
          if (idle_select && !sysclk_in_idle_on) begin
            state_d = HIWC_IDLE_OFF;
          end else if (idle_select) begin
            state_d = HIWC_IDLE_ON;
          end else if (sleep_kind) begin
            state_d = HIWC_SLEEP_WDT;
          end else begin
            state_d = HIWC_SLEEP_OFF;
          end
        end
      end
      HIWC_IDLE_OFF, HIWC_IDLE_ON: begin
        if (any_wake) begin
          state_d = HIWC_RUN;
        end
      end
      HIWC_SLEEP_OFF, HIWC_SLEEP_WDT: begin
        if (any_wake) begin
          // fast wake runs on sub clock while high oscillator settles
          state_d = fast_ok ? HIWC_RUN : HIWC_SETTLE_H;
        end
      end
      HIWC_SETTLE_H: begin
        if (cnt_done_h && osc_s[1]) begin
          state_d = low_pending_q ? HIWC_SETTLE_L : HIWC_RUN;
        end
      end
      HIWC_SETTLE_L: begin
        // core already runs; low settle finishes in background, then waits for a stable crystal
        if (cnt_done_l && osc_s[0]) begin
          state_d = HIWC_RUN;
        end
      end
      default: state_d = HIWC_RUN;
    endcase
  end

  // power-on starts with a high oscillator settle
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= HIWC_SETTLE_H;
    end else if (rst_s[1] && asleep) begin
      state_q <= HIWC_SETTLE_H;
    end else begin
      state_q <= state_d;
    end
  end

  // shared settle counter: restarts on each settle phase entry
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= HIWC_SETTLE_RST;
    end else if (state_q != state_d || !(state_q == HIWC_SETTLE_H || state_q == HIWC_SETTLE_L)) begin
      cnt_q <= HIWC_SETTLE_RST;
    end else if (!((state_q == HIWC_SETTLE_H && cnt_done_h) || (state_q == HIWC_SETTLE_L && cnt_done_l))) begin
      cnt_q <= cnt_q + SETTLE_W_L'(1);
    end
  end

  // low oscillator needs its own settle if it was off in sleep
  always_ff @(posedge clk) begin
    if (srst) begin
      low_pending_q <= 1'b1;
    end else if (halt_exec && state_q == HIWC_RUN) begin
      low_pending_q <= !idle_select && !sleep_kind;
    end else if (state_q == HIWC_SETTLE_L && cnt_done_l && osc_s[0]) begin
      low_pending_q <= 1'b0;
    end
  end

  // arm only requests that were low at halt
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_armed_q <= '0;
    end else if (halt_exec && state_q == HIWC_RUN) begin
      irq_armed_q <= ~irq_s;
    end else begin
      irq_armed_q <= irq_armed_q & ~irq_s | (irq_armed_q & irq_s);
    end
  end

  // ****************************************************************
  // clock gating and watchdog
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      sys_clk_en <= 1'b0;
      tb_clk_en <= 1'b1;
      sub_clk_en <= 1'b0;
      wdt_clk_en <= 1'b0;
      high_osc_en <= 1'b1;
      low_osc_en <= 1'b1;
      periph_on_slow <= 1'b0;
    end else begin
      sys_clk_en <= (state_d == HIWC_RUN) || (state_d == HIWC_IDLE_ON) ||
                    (state_d == HIWC_SETTLE_L);
      tb_clk_en <= (state_d != HIWC_SLEEP_OFF) && (state_d != HIWC_SLEEP_WDT);
      // sub clock follows watchdog enable when watchdog runs on it
      sub_clk_en <= (state_d == HIWC_IDLE_OFF) || (state_d == HIWC_IDLE_ON) ||
                    (state_d != HIWC_SLEEP_OFF && wdt_enable && wdt_on_sub);
      wdt_clk_en <= wdt_enable && (wdt_on_sub ? (state_d != HIWC_SLEEP_OFF) :
                    (state_d == HIWC_RUN || state_d == HIWC_IDLE_ON || state_d == HIWC_SETTLE_L));
      high_osc_en <= (state_d != HIWC_SLEEP_OFF) && (state_d != HIWC_SLEEP_WDT) &&
                     !(state_d == HIWC_IDLE_OFF && sys_on_slow);
      low_osc_en <= (state_d != HIWC_SLEEP_OFF) && (state_d != HIWC_SETTLE_H || !low_pending_q);
      periph_on_slow <= sys_on_slow;
    end
  end

  // watchdog cleared on any mode entry from run
  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= (state_q == HIWC_RUN && halt_exec) || (wdt_clr_exec && state_q == HIWC_RUN);
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  // halt sets, watchdog clear instruction clears; set wins
  always_ff @(posedge clk) begin
    if (srst) begin
      power_down_flag <= HIWC_PDF_RST;
    end else if (halt_exec && state_q == HIWC_RUN) begin
      power_down_flag <= 1'b1;
    end else if (wdt_clr_exec && state_q == HIWC_RUN) begin
      power_down_flag <= 1'b0;
    end
  end

  // time-out flag: cleared on entry, set by overflow while asleep
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_timeout_flag <= HIWC_TO_RST;
    end else if (asleep && rst_s[0]) begin
      watchdog_timeout_flag <= 1'b1;
    end else if (halt_exec && state_q == HIWC_RUN) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // resume decision
  // ****************************************************************
  logic wake_run;
  assign wake_run = (state_d == HIWC_RUN) && (state_q != HIWC_RUN);

  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_halted <= 1'b1;
      high_osc_ready <= 1'b0;
      slow_switch_ok <= 1'b0;
      mode_state <= HIWC_SETTLE_H;
    end else begin
      // core executes only when high oscillator ready or fast wake
      cpu_halted <= !(state_d == HIWC_RUN || state_d == HIWC_SETTLE_L);
      high_osc_ready <= (state_q == HIWC_SETTLE_H) ? (cnt_done_h && osc_s[1]) :
                        (high_osc_ready && state_d != HIWC_SLEEP_OFF && state_d != HIWC_SLEEP_WDT);
      if (any_wake && fast_ok) begin
        slow_switch_ok <= 1'b1;
      end else if (halt_exec) begin
        slow_switch_ok <= 1'b0;
      end
      mode_state <= state_d;
    end
  end

  // reset pulses and resume kind, captured at the wake instant
  always_ff @(posedge clk) begin
    if (srst) begin
      full_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
      resume_pulse <= 1'b0;
      resume_kind <= HIWC_RES_NONE;
      irq_take <= '0;
    end else begin
      full_reset <= any_wake && rst_s[1];
      pc_sp_reset <= any_wake && !rst_s[1] && rst_s[0];
      resume_pulse <= wake_run;
      irq_take <= '0;
      if (any_wake) begin
        if (rst_s[1] || rst_s[0]) begin
          resume_kind <= HIWC_RES_WDT;
        end else if (|(irq_wake & irq_enable) && !stack_full) begin
          resume_kind <= HIWC_RES_IRQ;
          irq_take <= irq_wake & irq_enable;
        end else begin
          resume_kind <= HIWC_RES_NEXT;
        end
      end
    end
  end
endmodule

// file: sim/hiwc_ctrl_asserts.sv
/*
  checker for hiwc_ctrl: mode entry on halt, clock gating, flags, wake.
  assumes it is bound to hiwc_ctrl and sees only its ports.
*/
`timescale 1ns/10ps
module hiwc_ctrl_asserts
  import hiwc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic halt_exec,
  input wire logic wdt_clr_exec,
  input wire logic idle_select,
  input wire logic sysclk_in_idle_on,
  input wire logic wdt_enable,
  input wire logic wdt_on_sub,
  input wire logic low_voltage_detect,
  input wire logic cpu_halted,
  input wire logic sys_clk_en,
  input wire logic tb_clk_en,
  input wire logic sub_clk_en,
  input wire logic wdt_clear,
  input wire logic high_osc_ready,
  input wire logic power_down_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic pc_sp_reset,
  input wire logic slow_switch_ok,
  input hiwc_state_t mode_state
);
  // ****************************************************************
  // halt entry and wake relations
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // a halt only counts while the core runs
  sequence halt_taken_s;
    halt_exec && mode_state == HIWC_RUN;
  endsequence

  idle_off_entry_a: assert property (halt_taken_s ##0 (idle_select && !sysclk_in_idle_on)
    |=> mode_state == HIWC_IDLE_OFF && cpu_halted) else $error("idle clock-off entry wrong");
  idle_off_clocks_a: assert property (mode_state == HIWC_IDLE_OFF
    |-> !sys_clk_en && tb_clk_en && sub_clk_en) else $error("idle clock-off gating wrong");
  idle_on_entry_a: assert property (halt_taken_s ##0 (idle_select && sysclk_in_idle_on)
    |=> mode_state == HIWC_IDLE_ON && sys_clk_en && tb_clk_en && sub_clk_en) else $error("idle clock-on entry wrong");
  halt_wdt_clr_a: assert property (halt_taken_s ##0 (idle_select && wdt_enable &&
    (wdt_on_sub || sysclk_in_idle_on)) |=> wdt_clear) else $error("watchdog not cleared on halt");
  halt_flags_a: assert property (halt_taken_s |=> power_down_flag && !watchdog_timeout_flag)
    else $error("flags wrong after halt");
  clr_pdf_a: assert property (wdt_clr_exec && !halt_exec && mode_state == HIWC_RUN
    |=> !power_down_flag) else $error("power-down flag not cleared");
  sleep_off_entry_a: assert property (halt_taken_s ##0 (!idle_select && !wdt_enable &&
    !low_voltage_detect) |=> mode_state == HIWC_SLEEP_OFF) else $error("sleep all-off entry wrong");
  sleep_wdt_entry_a: assert property (halt_taken_s ##0 (!idle_select && (wdt_enable ||
    low_voltage_detect)) |=> mode_state == HIWC_SLEEP_WDT) else $error("sleep watchdog-on entry wrong");
  wdt_wake_flag_a: assert property (pc_sp_reset |-> ##[0:2] watchdog_timeout_flag)
    else $error("timeout flag missing on watchdog wake");
  run_after_ready_a: assert property ($fell(cpu_halted) && !slow_switch_ok |-> high_osc_ready)
    else $error("core released before high oscillator ready");
endmodule

// file: sim/hiwc_core_model.sv
/*
  core model: retires halt and watchdog clear instructions on command.
  assumes commands arrive at the falling edge; nothing retires while halted.
*/
`timescale 1ns/10ps
module hiwc_core_model (
  input wire logic clk,
  input wire logic cpu_halted,
  input wire logic halt_cmd,
  input wire logic clr_cmd,
  output logic halt_exec = 1'b0,
  output logic wdt_clr_exec = 1'b0
);
  // ****************************************************************
  // instruction retire
  // ****************************************************************
  // a stopped core cannot execute, so commands are dropped while halted
  always @(negedge clk) begin
    halt_exec <= halt_cmd && !cpu_halted;
    wdt_clr_exec <= clr_cmd && !cpu_halted;
  end
endmodule

// file: sim/testbench.sv
/*
  testbench for hiwc_ctrl: each low-power mode entered and woken.
  assumes the core model issues halts; inputs change at the falling edge.
*/
`timescale 1ns/10ps
module testbench
  import hiwc_pkg::*;
;
  // ****************************************************************
  // stimulus and observation
  // ****************************************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic halt_cmd = 1'b0, clr_cmd = 1'b0, halt_exec, wdt_clr_exec;
  logic idle_select = 1'b0, sysclk_in_idle_on = 1'b0, wdt_enable = 1'b0, wdt_on_sub = 1'b1;
  logic low_voltage_detect = 1'b0, fast_wake_enable = 1'b0, hosc_is_sys = 1'b1, sys_on_slow = 1'b0;
  logic high_osc_stable = 1'b1, low_osc_stable = 1'b1, ext_reset_wake = 1'b0, wdt_overflow = 1'b0;
  logic stack_full = 1'b0;
  logic [7:0] porta_pins = 8'hFF, porta_wake_enable = 8'h00, irq_req = 8'h00, irq_enable = 8'h00;
  logic cpu_halted, sys_clk_en, tb_clk_en, sub_clk_en, wdt_clk_en, wdt_clear, periph_on_slow;
  logic high_osc_en, low_osc_en, high_osc_ready, power_down_flag, watchdog_timeout_flag;
  logic full_reset, pc_sp_reset, resume_pulse, slow_switch_ok;
  logic [7:0] irq_take;
  hiwc_resume_t resume_kind;
  hiwc_state_t mode_state;
  int errors = 0, n_tests = 0, cycles = 0, waited = 0;

  always #4 clk = ~clk;

  hiwc_ctrl u_dut (.clk, .srst, .halt_exec, .wdt_clr_exec, .idle_select, .sysclk_in_idle_on, .wdt_enable,
    .wdt_on_sub, .low_voltage_detect, .fast_wake_enable, .hosc_is_sys, .sys_on_slow, .high_osc_stable,
    .low_osc_stable, .ext_reset_wake, .wdt_overflow, .porta_pins, .porta_wake_enable, .irq_req, .irq_enable,
    .stack_full, .cpu_halted, .sys_clk_en, .tb_clk_en, .sub_clk_en, .wdt_clk_en, .wdt_clear, .periph_on_slow,
    .high_osc_en, .low_osc_en, .high_osc_ready, .power_down_flag, .watchdog_timeout_flag, .full_reset,
    .pc_sp_reset, .resume_pulse, .resume_kind, .irq_take, .slow_switch_ok, .mode_state);
  hiwc_core_model u_core (.clk, .cpu_halted, .halt_cmd, .clr_cmd, .halt_exec, .wdt_clr_exec);

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wrap_up;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task step(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait: 0 resume, 1 core running, 2 full reset, 3 pc/sp reset, 4 run state
  task wait_ev(input int which, input int lim);
    waited = 0;
    while (waited < lim && !((which == 0 && resume_pulse === 1'b1) || (which == 1 && cpu_halted === 1'b0) ||
        (which == 2 && full_reset === 1'b1) || (which == 3 && pc_sp_reset === 1'b1) ||
        (which == 4 && mode_state === HIWC_RUN))) begin
      step(1);
      waited++;
    end
    chk(8'(waited < lim), 8'h01);
  endtask

  // the core retires the halt one cycle after the command
  task halt_now;
    halt_cmd <= 1'b1;
    step(1);
    halt_cmd <= 1'b0;
    step(3);
  endtask

  task t_power_on;
    srst <= 1'b0;
    step(1);
    chk(8'({cpu_halted, high_osc_ready, power_down_flag}), 8'h04);
    wait_ev(1, HIWC_HOSC_SETTLE_CYC + 100);
    chk(8'(waited >= HIWC_HOSC_SETTLE_CYC - 2), 8'h01);
    chk(8'(high_osc_ready), 8'h01);
    // halts are refused until the low settle is over
    wait_ev(4, HIWC_LOSC_SETTLE_CYC + 100);
  endtask

  task t_idle_off;
    idle_select <= 1'b1;
    wdt_enable <= 1'b1;
    porta_wake_enable <= 8'h04;
    halt_now;
    chk(8'(mode_state), 8'(HIWC_IDLE_OFF));
    chk(8'({cpu_halted, sys_clk_en, tb_clk_en, sub_clk_en, wdt_clk_en}), 8'h17);
    chk(8'({power_down_flag, watchdog_timeout_flag}), 8'h02);
    porta_pins <= 8'hFD; // a pin without wake enable falls first
    step(8);
    chk(8'(cpu_halted), 8'h01);
    porta_pins <= 8'hF9;
    wait_ev(0, 20);
    chk(8'(resume_kind), 8'(HIWC_RES_NEXT));
    chk(8'(mode_state), 8'(HIWC_RUN));
    porta_pins <= 8'hFF;
  endtask

  task t_idle_on;
    sysclk_in_idle_on <= 1'b1;
    irq_enable <= 8'h02;
    halt_now;
    chk(8'(mode_state), 8'(HIWC_IDLE_ON));
    chk(8'({cpu_halted, sys_clk_en, tb_clk_en, sub_clk_en, wdt_clk_en}), 8'h1F);
    irq_req <= 8'h02;
    wait_ev(0, 20);
    chk(8'(resume_kind), 8'(HIWC_RES_IRQ));
    chk(irq_take, 8'h02);
    clr_cmd <= 1'b1;
    step(1);
    clr_cmd <= 1'b0;
    step(3);
    chk(8'(power_down_flag), 8'h00);
  endtask

  // irq bit 1 is already high at entry; bit 4 is masked
  task t_irq_masked;
    halt_now;
    step(8);
    chk(8'(cpu_halted), 8'h01);
    irq_req <= 8'h12;
    wait_ev(0, 20);
    chk(8'(resume_kind), 8'(HIWC_RES_NEXT));
    chk(irq_take, 8'h00);
    irq_req <= 8'h00;
    // enabled request with no stack room: resume after the halt
    stack_full <= 1'b1;
    step(2);
    halt_now;
    irq_req <= 8'h02;
    wait_ev(0, 20);
    chk(8'(resume_kind), 8'(HIWC_RES_NEXT));
    chk(irq_take, 8'h00);
    irq_req <= 8'h00;
    stack_full <= 1'b0;
  endtask

  task t_sleep_wdt;
    idle_select <= 1'b0;
    halt_now;
    chk(8'(mode_state), 8'(HIWC_SLEEP_WDT));
    chk(8'(sub_clk_en), 8'h01);
    wdt_overflow <= 1'b1;
    wait_ev(3, 20);
    wdt_overflow <= 1'b0;
    wait_ev(1, 2 * HIWC_HOSC_SETTLE_CYC + 100);
    chk(8'({watchdog_timeout_flag, power_down_flag}), 8'h03);
    chk(8'(resume_kind), 8'(HIWC_RES_WDT));
  endtask

  // low oscillator stops in all-off sleep, so it settles after the high one
  task t_sleep_off;
    wdt_enable <= 1'b0;
    halt_now;
    chk(8'(mode_state), 8'(HIWC_SLEEP_OFF));
    chk(8'(sub_clk_en), 8'h00);
    chk(8'({high_osc_en, low_osc_en}), 8'h00);
    low_osc_stable <= 1'b0;
    ext_reset_wake <= 1'b1;
    wait_ev(2, 20);
    chk(8'({high_osc_en, low_osc_en}), 8'h02);
    ext_reset_wake <= 1'b0;
    wait_ev(1, HIWC_HOSC_SETTLE_CYC + 100);
    step(2);
    chk(8'(mode_state), 8'(HIWC_SETTLE_L));
    chk(8'({high_osc_en, low_osc_en}), 8'h03);
    low_osc_stable <= 1'b1;
    wait_ev(4, HIWC_LOSC_SETTLE_CYC + 100);
  endtask

  task t_fast;
    wdt_enable <= 1'b1;
    fast_wake_enable <= 1'b1;
    halt_now;
    porta_pins <= 8'hFB;
    wait_ev(0, 20);
    chk(8'(slow_switch_ok), 8'h01);
    porta_pins <= 8'hFF;
    sys_on_slow <= 1'b1;
    step(3);
    chk(8'(periph_on_slow), 8'h01);
  endtask

  // hang guard: the whole sequence needs about five thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up;
    end
  end

  initial begin
    step(2);
    t_power_on;
    t_idle_off;
    t_idle_on;
    t_irq_masked;
    t_sleep_wdt;
    t_sleep_off;
    t_fast;
    wrap_up;
  end
endmodule

bind hiwc_ctrl hiwc_ctrl_asserts u_chk (.clk, .srst, .halt_exec, .wdt_clr_exec, .idle_select, .sysclk_in_idle_on,
  .wdt_enable, .wdt_on_sub, .low_voltage_detect, .cpu_halted, .sys_clk_en, .tb_clk_en, .sub_clk_en, .wdt_clear,
  .high_osc_ready, .power_down_flag, .watchdog_timeout_flag, .pc_sp_reset, .slow_switch_ok, .mode_state);
